// [inc/pmpm_defines.svh]
// Purpose: constants for the program memory partition map
// Assumes: one clock, synchronous reset
// Notes: addresses are program word addresses
`ifndef PMPM_DEFINES_SVH
`define PMPM_DEFINES_SVH

// ****************************************
// address space
// ****************************************
`define PMPM_PC_W 15
`define PMPM_WORD_W 14
`define PMPM_RESET_VEC 15'h0000
`define PMPM_INT_VEC 15'h0004
`define PMPM_REV_ADDR 16'h8005
`define PMPM_DEV_ADDR 16'h8006
`define PMPM_CFG_LO 16'h8007
`define PMPM_CFG_HI 16'h800b
`define PMPM_EE_LO 16'hf000
`define PMPM_EE_HI 16'hf0ff
`define PMPM_SAF_WORDS 15'h0080

// ****************************************
// identification word layout
// ****************************************
`define PMPM_ID_RSV13 13
`define PMPM_ID_RSV12 12
`define PMPM_MJR_LSB 6

// ****************************************
// boot block end addresses
// ****************************************
`define PMPM_BB_END_7 15'h01ff
`define PMPM_BB_END_6 15'h03ff
`define PMPM_BB_END_5 15'h07ff
`define PMPM_BB_END_4 15'h0fff
`define PMPM_BB_END_3 15'h1fff
`define PMPM_BB_END_LO 15'h3fff

// ****************************************
// indirect pointer
// ****************************************
`define PMPM_PTR_PFM_BIT 7
`define PMPM_PTR_W 16
`define PMPM_PTR_HI_LSB 8
`define PMPM_SPACE_BIT 15

`endif

// [inc/pmpm_pkg.sv]
// Purpose: shared types for the program memory partition map
// Assumes: constants come from pmpm_defines.svh
// Notes: none
package pmpm_pkg;
    typedef enum logic [1:0] {
        PMPM_REG_APP = 2'b00,
        PMPM_REG_BOOT = 2'b01,
        PMPM_REG_SAF = 2'b10
    } pmpm_region_t;

    typedef enum logic [1:0] {
        PMPM_RD_IDLE = 2'b00,
        PMPM_RD_WAIT = 2'b01,
        PMPM_RD_DONE = 2'b10
    } pmpm_rd_state_t;
endpackage

// [inc/pmpm_cfg_if.sv]
// Purpose: carries partition configuration between the map modules
// Assumes: one clock domain
// Notes: levels only
`timescale 1ns/1ps
interface pmpm_cfg_if;
    logic boot_partition_enable_n;
    logic [2:0] boot_partition_size;
    logic storage_area_enable_n;
    logic [14:0] mem_last;
    logic [14:0] boot_last;
    logic [14:0] saf_first;
    modport src (output boot_partition_enable_n, output boot_partition_size, output storage_area_enable_n,
        output mem_last, input boot_last, input saf_first);
    modport map (input boot_partition_enable_n, input boot_partition_size, input storage_area_enable_n,
        input mem_last, output boot_last, output saf_first);
endinterface

// [logic/pmpm_bounds.sv]
// Purpose: works out partition boundaries from configuration
// Assumes: memory size is a power of two
// Notes: pure combinational
`timescale 1ns/1ps
`include "pmpm_defines.svh"
module pmpm_bounds (
    // configuration
    pmpm_cfg_if.map cfg
);
    logic [14:0] sel_last;
    logic [14:0] half_last;

    always_comb begin
        unique case (cfg.boot_partition_size)
            3'b111: sel_last = `PMPM_BB_END_7;
            3'b110: sel_last = `PMPM_BB_END_6;
            3'b101: sel_last = `PMPM_BB_END_5;
            3'b100: sel_last = `PMPM_BB_END_4;
            3'b011: sel_last = `PMPM_BB_END_3;
            default: sel_last = `PMPM_BB_END_LO;
        endcase
    end

    // clamp to half of memory
    assign half_last = cfg.mem_last >> 1;
    assign cfg.boot_last = (sel_last > half_last) ? half_last : sel_last;
    assign cfg.saf_first = cfg.mem_last - (`PMPM_SAF_WORDS - 15'h0001);
endmodule

// [logic/pmpm_classify.sv]
// Purpose: classifies a program address into its partition
// Assumes: address already wrapped into implemented space
// Notes: pure combinational
`timescale 1ns/1ps
module pmpm_classify (
    // configuration
    pmpm_cfg_if.map cfg,
    // address
    input wire logic [14:0] addr,
    output pmpm_pkg::pmpm_region_t region
);
    always_comb begin
        region = pmpm_pkg::PMPM_REG_APP;
        if (!cfg.storage_area_enable_n && addr >= cfg.saf_first) begin
            region = pmpm_pkg::PMPM_REG_SAF;
        end else if (!cfg.boot_partition_enable_n && addr <= cfg.boot_last) begin
            region = pmpm_pkg::PMPM_REG_BOOT;
        end
    end
endmodule

// [logic/pmpm_map.sv]
// Purpose: program memory address map, partitions, protection and id words
// Assumes: core and nvm controller sit outside, synchronous to mclk
// Notes: configuration bits are latched from config memory on load
`timescale 1ns/1ps
`include "pmpm_defines.svh"

// ****************************************
// program memory partition map
// ****************************************
module pmpm_map #(
    parameter int MEM_WORDS = 8192,
    parameter logic [11:0] PART_ID = 12'h5a5, // arbitrary value
    parameter logic [5:0] MAJOR_REV = 6'h01, // arbitrary value
    parameter logic [5:0] MINOR_REV = 6'h00 // arbitrary value
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // configuration load and bulk erase
    input wire logic cfg_load,
    input wire logic boot_partition_enable_n,
    input wire logic [2:0] boot_partition_size,
    input wire logic storage_area_enable_n,
    input wire logic application_write_protect,
    input wire logic boot_write_protect,
    input wire logic config_write_protect,
    input wire logic eeprom_write_protect,
    input wire logic storage_write_protect,
    input wire logic bulk_erase,
    // fetch
    input wire logic fetch_req,
    input wire logic int_entry,
    input wire logic jump_req,
    input wire logic [14:0] jump_addr,
    output logic [14:0] pc,
    output logic fetch_valid,
    output logic exec_violation_reset,
    output logic exec_violation_flag,
    // indirect access port
    input wire logic ind_req,
    input wire logic ind_we,
    input wire logic [15:0] indirect_pointer,
    input wire logic [13:0] pfm_rdata,
    output logic [14:0] pfm_raddr,
    output logic pfm_rd,
    output logic ind_pfm_busy,
    output logic ind_done,
    output logic [7:0] ind_rdata,
    // identification words
    input wire logic [15:0] id_addr,
    input wire logic id_rd,
    output logic [15:0] id_rdata,
    // nvm write checks
    input wire logic nvm_wr_req,
    input wire logic [15:0] nvm_wr_addr,
    input wire logic write_fault_clr,
    output logic nvm_wr_grant,
    output logic write_fault_flag
);
    localparam logic [14:0] LAST = 15'(MEM_WORDS - 1);

    typedef struct packed {
        logic bb_en_n;
        logic [2:0] bb_size;
        logic saf_en_n;
        logic wp_app;
        logic wp_boot;
        logic wp_cfg;
        logic wp_ee;
        logic wp_saf;
        logic [14:0] pc;
        logic fetch_valid;
        logic mviol_rst;
        logic mviol_flag;
        pmpm_pkg::pmpm_rd_state_t rd_st;
        logic [14:0] pfm_raddr;
        logic pfm_rd;
        logic ind_busy;
        logic ind_done;
        logic [7:0] ind_rdata;
        logic [15:0] id_rdata;
        logic wr_grant;
        logic wr_fault;
    } pmpm_state_t;

    pmpm_state_t st_r;
    pmpm_state_t st_nxt;

    // fetch and write paths each get their own boundary copy
    pmpm_cfg_if cfg_pc ();
    pmpm_cfg_if cfg_wr ();
    pmpm_pkg::pmpm_region_t pc_region;
    pmpm_pkg::pmpm_region_t wr_region;
    logic [14:0] wr_wrapped;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [14:0] wrap_addr(input logic [14:0] a);
        wrap_addr = a & LAST;
    endfunction

    function automatic logic is_pfm(input logic [15:0] a);
        is_pfm = (a[`PMPM_SPACE_BIT] == 1'b0);
    endfunction

    // bit 7 of the pointer high byte steers the access into program memory
    function automatic logic ptr_to_pfm(input logic [15:0] p);
        ptr_to_pfm = p[`PMPM_PTR_HI_LSB + `PMPM_PTR_PFM_BIT];
    endfunction

    function automatic logic in_span(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        in_span = (a >= lo) && (a <= hi);
    endfunction

    // words are built whole so unused upper bits always read zero
    function automatic logic [15:0] id_word(input logic [15:0] a);
        id_word = 16'h0000;
        if (a == `PMPM_DEV_ADDR) begin
            id_word[11:0] = PART_ID;
            id_word[`PMPM_ID_RSV13] = 1'b1;
            id_word[`PMPM_ID_RSV12] = 1'b1;
        end else if (a == `PMPM_REV_ADDR) begin
            id_word[`PMPM_ID_RSV13] = 1'b1;
            id_word[`PMPM_ID_RSV12] = 1'b0;
            id_word[11:`PMPM_MJR_LSB] = MAJOR_REV;
            id_word[`PMPM_MJR_LSB - 1:0] = MINOR_REV;
        end
    endfunction

    // a cleared protect bit blocks the write; anything outside the map is refused too
    function automatic logic wr_blocked(input logic [15:0] a, input pmpm_pkg::pmpm_region_t r,
        input pmpm_state_t s);
        if (is_pfm(a)) begin
            unique case (r)
                pmpm_pkg::PMPM_REG_BOOT: wr_blocked = !s.wp_boot;
                pmpm_pkg::PMPM_REG_SAF: wr_blocked = !s.wp_saf;
                default: wr_blocked = !s.wp_app;
            endcase
        end else if (in_span(a, `PMPM_CFG_LO, `PMPM_CFG_HI)) begin
            wr_blocked = !s.wp_cfg;
        end else if (in_span(a, `PMPM_EE_LO, `PMPM_EE_HI)) begin
            wr_blocked = !s.wp_ee;
        end else begin
            wr_blocked = 1'b1;
        end
    endfunction

    // ****************************************
    // partition classification
    // ****************************************
    assign cfg_pc.boot_partition_enable_n = st_r.bb_en_n;
    assign cfg_pc.boot_partition_size = st_r.bb_size;
    assign cfg_pc.storage_area_enable_n = st_r.saf_en_n;
    assign cfg_pc.mem_last = LAST;
    assign cfg_wr.boot_partition_enable_n = st_r.bb_en_n;
    assign cfg_wr.boot_partition_size = st_r.bb_size;
    assign cfg_wr.storage_area_enable_n = st_r.saf_en_n;
    assign cfg_wr.mem_last = LAST;
    assign wr_wrapped = wrap_addr(nvm_wr_addr[14:0]);

    pmpm_bounds u_bounds_pc (
        .cfg(cfg_pc)
    );

    pmpm_bounds u_bounds_wr (
        .cfg(cfg_wr)
    );

    pmpm_classify u_class_pc (
        .cfg(cfg_pc),
        .addr(st_r.pc),
        .region(pc_region)
    );

    pmpm_classify u_class_wr (
        .cfg(cfg_wr),
        .addr(wr_wrapped),
        .region(wr_region)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic prot;
        logic take;
        prot = wr_blocked(nvm_wr_addr, wr_region, st_r);
        take = fetch_req && !st_r.ind_busy;
        st_nxt = st_r;
        st_nxt.mviol_rst = 1'b0;
        st_nxt.ind_done = 1'b0;
        st_nxt.pfm_rd = 1'b0;
        st_nxt.wr_grant = 1'b0;

        // configuration: protection only tightens until bulk erase
        if (bulk_erase) begin
            st_nxt.wp_app = 1'b1;
            st_nxt.wp_boot = 1'b1;
            st_nxt.wp_cfg = 1'b1;
            st_nxt.wp_ee = 1'b1;
            st_nxt.wp_saf = 1'b1;
            st_nxt.bb_en_n = 1'b1;
            st_nxt.bb_size = 3'h7;
            st_nxt.saf_en_n = 1'b1;
        end else if (cfg_load) begin
            st_nxt.wp_app = st_r.wp_app & application_write_protect;
            st_nxt.wp_boot = st_r.wp_boot & boot_write_protect;
            st_nxt.wp_cfg = st_r.wp_cfg & config_write_protect;
            st_nxt.wp_ee = st_r.wp_ee & eeprom_write_protect;
            st_nxt.wp_saf = st_r.wp_saf & storage_write_protect;
            // size is frozen once the boot block is enabled
            if (st_r.bb_en_n) begin
                st_nxt.bb_size = boot_partition_size;
            end
            st_nxt.bb_en_n = boot_partition_enable_n;
            st_nxt.saf_en_n = storage_area_enable_n;
        end

        // fetch sequencing
        if (int_entry) begin
            st_nxt.pc = `PMPM_INT_VEC;
        end else if (jump_req) begin
            st_nxt.pc = wrap_addr(jump_addr);
        end else if (take) begin
            st_nxt.pc = wrap_addr(st_r.pc + 15'h0001);
        end
        st_nxt.fetch_valid = take;
        // the check looks at the address being fetched, not its successor
        if (take && pc_region == pmpm_pkg::PMPM_REG_SAF) begin
            st_nxt.mviol_rst = 1'b1;
            st_nxt.mviol_flag = 1'b0;
            st_nxt.pc = `PMPM_RESET_VEC;
        end

        // indirect read of program memory costs two extra cycles
        unique case (st_r.rd_st)
            pmpm_pkg::PMPM_RD_IDLE: begin
                if (ind_req && ptr_to_pfm(indirect_pointer) && !ind_we) begin
                    st_nxt.pfm_raddr = wrap_addr(indirect_pointer[14:0]);
                    st_nxt.pfm_rd = 1'b1;
                    st_nxt.ind_busy = 1'b1;
                    st_nxt.rd_st = pmpm_pkg::PMPM_RD_WAIT;
                end else if (ind_req && ptr_to_pfm(indirect_pointer)) begin
                    st_nxt.ind_done = 1'b1;
                end
            end
            pmpm_pkg::PMPM_RD_WAIT: begin
                st_nxt.rd_st = pmpm_pkg::PMPM_RD_DONE;
            end
            pmpm_pkg::PMPM_RD_DONE: begin
                st_nxt.ind_rdata = pfm_rdata[7:0];
                st_nxt.ind_done = 1'b1;
                st_nxt.ind_busy = 1'b0;
                st_nxt.rd_st = pmpm_pkg::PMPM_RD_IDLE;
            end
            default: begin
                st_nxt.rd_st = pmpm_pkg::PMPM_RD_IDLE;
                st_nxt.ind_busy = 1'b0;
            end
        endcase

        // identification words
        if (id_rd) begin
            st_nxt.id_rdata = id_word(id_addr);
        end

        // write protection check, set wins over clear
        if (write_fault_clr) begin
            st_nxt.wr_fault = 1'b0;
        end
        if (nvm_wr_req) begin
            st_nxt.wr_grant = !prot;
            if (prot) begin
                st_nxt.wr_fault = 1'b1;
            end
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            // protection starts off and both optional blocks start disabled
            st_r <= '0;
            st_r.bb_en_n <= 1'b1;
            st_r.bb_size <= 3'h7;
            st_r.saf_en_n <= 1'b1;
            st_r.wp_app <= 1'b1;
            st_r.wp_boot <= 1'b1;
            st_r.wp_cfg <= 1'b1;
            st_r.wp_ee <= 1'b1;
            st_r.wp_saf <= 1'b1;
            st_r.pc <= `PMPM_RESET_VEC;
            st_r.mviol_flag <= 1'b1;
            st_r.rd_st <= pmpm_pkg::PMPM_RD_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign pc = st_r.pc;
    assign fetch_valid = st_r.fetch_valid;
    assign exec_violation_reset = st_r.mviol_rst;
    assign exec_violation_flag = st_r.mviol_flag;
    assign pfm_raddr = st_r.pfm_raddr;
    assign pfm_rd = st_r.pfm_rd;
    assign ind_pfm_busy = st_r.ind_busy;
    assign ind_done = st_r.ind_done;
    assign ind_rdata = st_r.ind_rdata;
    assign id_rdata = st_r.id_rdata;
    assign nvm_wr_grant = st_r.wr_grant;
    assign write_fault_flag = st_r.wr_fault;
endmodule

// [verif/pmpm_map_assertions.sv]
// Purpose: port-level assertions for the program memory partition map
// Assumes: MEM_WORDS is a power of two, one clock domain
// Notes: bound to every pmpm_map instance
`timescale 1ns/1ps
module pmpm_map_chk #(
    parameter int MEM_WORDS = 8192
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // fetch
    input wire logic fetch_req,
    input wire logic int_entry,
    input wire logic jump_req,
    input wire logic [14:0] jump_addr,
    input wire logic [14:0] pc,
    input wire logic fetch_valid,
    input wire logic exec_violation_reset,
    input wire logic exec_violation_flag,
    // indirect access
    input wire logic ind_req,
    input wire logic ind_we,
    input wire logic [15:0] indirect_pointer,
    input wire logic [13:0] pfm_rdata,
    input wire logic [14:0] pfm_raddr,
    input wire logic pfm_rd,
    input wire logic ind_pfm_busy,
    input wire logic ind_done,
    input wire logic [7:0] ind_rdata,
    // id words and nvm checks
    input wire logic [15:0] id_addr,
    input wire logic id_rd,
    input wire logic [15:0] id_rdata,
    input wire logic nvm_wr_req,
    input wire logic [15:0] nvm_wr_addr,
    input wire logic nvm_wr_grant,
    input wire logic write_fault_flag
);
    localparam logic [14:0] MASK = 15'(MEM_WORDS - 1);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    // ****************************************
    // assertions
    // ****************************************
    chk_fetch_step: assert property (fetch_req && !ind_pfm_busy && !int_entry && !jump_req |=>
        (fetch_valid && pc == (($past(pc) + 15'h0001) & MASK)) || exec_violation_reset)
        else $error("fetch did not step pc");
    chk_int_vector: assert property (int_entry && !fetch_req |=> pc == 15'h0004)
        else $error("interrupt entry not at four");
    chk_jump_wrap: assert property (jump_req && !int_entry && !fetch_req && !ind_pfm_busy |=>
        pc == ($past(jump_addr) & MASK))
        else $error("jump target not wrapped");
    chk_reset_start: assert property ($fell(reset) |-> pc == 15'h0000 && exec_violation_flag)
        else $error("bad state after reset");
    chk_ind_read: assert property (ind_req && !ind_we && indirect_pointer[15] && !ind_pfm_busy |=>
        pfm_rd && ind_pfm_busy && pfm_raddr == (15'($past(indirect_pointer)) & MASK) ##1 !pfm_rd && !ind_done
        ##1 ind_done && !ind_pfm_busy)
        else $error("indirect read sequence wrong");
    chk_ind_low_byte: assert property (ind_done && $past(pfm_rd, 2) |-> ind_rdata == 8'($past(pfm_rdata)))
        else $error("indirect read data wrong");
    chk_ind_write: assert property (ind_req && ind_we && indirect_pointer[15] && !ind_pfm_busy |=>
        ind_done && !pfm_rd)
        else $error("indirect write touched memory");
    chk_data_space: assert property (ind_req && !indirect_pointer[15] |=> !pfm_rd)
        else $error("data access reached program memory");
    chk_viol_out: assert property (exec_violation_reset |-> pc == 15'h0000 && !exec_violation_flag)
        else $error("violation reset state wrong");
    chk_devid_bits: assert property (id_rd && id_addr == 16'h8006 |=> id_rdata[15:12] == 4'h3)
        else $error("device word upper bits wrong");
    chk_fault_unmap: assert property (nvm_wr_req && nvm_wr_addr == 16'h8006 |=>
        write_fault_flag && !nvm_wr_grant)
        else $error("id word write not refused");
endmodule

bind pmpm_map pmpm_map_chk #(.MEM_WORDS(MEM_WORDS)) u_chk (.mclk, .reset, .fetch_req, .int_entry, .jump_req,
    .jump_addr, .pc, .fetch_valid, .exec_violation_reset, .exec_violation_flag, .ind_req, .ind_we,
    .indirect_pointer, .pfm_rdata, .pfm_raddr, .pfm_rd, .ind_pfm_busy, .ind_done, .ind_rdata, .id_addr,
    .id_rd, .id_rdata, .nvm_wr_req, .nvm_wr_addr, .nvm_wr_grant, .write_fault_flag);

// [verif/pmpm_mem_model.sv]
// Purpose: program flash array seen from the map's read port
// Assumes: word is valid in the cycle after the read pulse
// Notes: word content is a fixed function of its address
`timescale 1ns/1ps
module pmpm_mem_model (
    // clock
    input wire logic mclk,
    // read request
    input wire logic pfm_rd,
    input wire logic [14:0] pfm_raddr,
    // read data
    output logic [13:0] pfm_rdata
);
    initial pfm_rdata = 14'h0000;
    // data stands one cycle only; junk after it exposes a late sample
    always @(posedge mclk) begin
        if (pfm_rd) begin
            pfm_rdata <= {pfm_raddr[13:8], pfm_raddr[7:0] ^ 8'h3c};
        end else begin
            pfm_rdata <= ~pfm_rdata;
        end
    end
endmodule

// [verif/program_memory_partition_map_tb.sv]
// Purpose: self-checking bench for the program memory partition map
// Assumes: 4096-word memory, so larger boot sizes clamp
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module program_memory_partition_map_tb;
    localparam int MEM = 4096;
    localparam logic [11:0] P_ID = 12'h9c3; // arbitrary value
    localparam logic [5:0] P_MJ = 6'h2a; // arbitrary value
    localparam logic [5:0] P_MN = 6'h15; // arbitrary value
    logic mclk = 1'b0, reset = 1'b1, cfg_load = 1'b0, bulk_erase = 1'b0;
    logic boot_partition_enable_n = 1'b1, storage_area_enable_n = 1'b1;
    logic [2:0] boot_partition_size = 3'h7;
    logic application_write_protect = 1'b1, boot_write_protect = 1'b1, config_write_protect = 1'b1;
    logic eeprom_write_protect = 1'b1, storage_write_protect = 1'b1;
    logic fetch_req = 1'b0, int_entry = 1'b0, jump_req = 1'b0, ind_req = 1'b0, ind_we = 1'b0, id_rd = 1'b0;
    logic nvm_wr_req = 1'b0, write_fault_clr = 1'b0;
    logic [14:0] jump_addr = 15'h0000;
    logic [15:0] indirect_pointer = 16'h0000, id_addr = 16'h0000, nvm_wr_addr = 16'h0000;
    logic [13:0] pfm_rdata;
    logic [14:0] pc, pfm_raddr;
    logic fetch_valid, exec_violation_reset, exec_violation_flag, pfm_rd, ind_pfm_busy, ind_done;
    logic nvm_wr_grant, write_fault_flag;
    logic [7:0] ind_rdata;
    logic [15:0] id_rdata;
    int num_errors = 0;
    int checked = 0;

    pmpm_map #(.MEM_WORDS(MEM), .PART_ID(P_ID), .MAJOR_REV(P_MJ), .MINOR_REV(P_MN)) dut (.mclk, .reset,
        .cfg_load, .boot_partition_enable_n, .boot_partition_size, .storage_area_enable_n,
        .application_write_protect, .boot_write_protect, .config_write_protect, .eeprom_write_protect,
        .storage_write_protect, .bulk_erase, .fetch_req, .int_entry, .jump_req, .jump_addr, .pc, .fetch_valid,
        .exec_violation_reset, .exec_violation_flag, .ind_req, .ind_we, .indirect_pointer, .pfm_rdata,
        .pfm_raddr, .pfm_rd, .ind_pfm_busy, .ind_done, .ind_rdata, .id_addr, .id_rd, .id_rdata, .nvm_wr_req,
        .nvm_wr_addr, .write_fault_clr, .nvm_wr_grant, .write_fault_flag);
    pmpm_mem_model u_mem (.mclk, .pfm_rd, .pfm_raddr, .pfm_rdata);

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic tick(int n = 1);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk(logic [15:0] got, logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (num_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cfg(logic erase, logic bn, logic [2:0] sz, logic sn, logic [4:0] w);
        bulk_erase = erase;
        tick();
        bulk_erase = 1'b0;
        {boot_partition_enable_n, boot_partition_size, storage_area_enable_n} = {bn, sz, sn};
        {application_write_protect, boot_write_protect, config_write_protect, eeprom_write_protect,
            storage_write_protect} = w;
        cfg_load = 1'b1;
        tick();
        cfg_load = 1'b0;
    endtask

    // clear rides with the request; a new fault wins over it
    task automatic nvm_wr(logic [15:0] a, logic f);
        {nvm_wr_req, write_fault_clr, nvm_wr_addr} = {2'b11, a};
        tick();
        {nvm_wr_req, write_fault_clr} = 2'b00;
        chk(nvm_wr_grant, !f);
        chk(write_fault_flag, f);
    endtask

    task automatic id_chk(logic [15:0] a, logic [15:0] e);
        {id_rd, id_addr} = {1'b1, a};
        tick();
        id_rd = 1'b0;
        chk(id_rdata, e);
    endtask

    task automatic step(logic f, logic i, logic j, logic [14:0] a);
        {fetch_req, int_entry, jump_req, jump_addr} = {f, i, j, a};
        tick();
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_fetch();
        chk(pc, 15'h0000);
        chk(exec_violation_flag, 1'b1);
        step(1, 0, 0, 15'h0000);
        chk(pc, 15'h0001);
        chk(fetch_valid, 1'b1);
        step(0, 0, 1, 15'h7ffe);
        chk(pc, 15'h0ffe);
        step(1, 0, 0, 15'h0000);
        step(1, 0, 0, 15'h0000);
        chk(pc, 15'h0000);
        step(0, 1, 1, 15'h0100);
        chk(pc, 15'h0004);
        step(0, 0, 0, 15'h0000);
    endtask

    task automatic t_ids();
        id_chk(16'h8006, {4'h3, P_ID});
        id_chk(16'h8005, {4'h2, P_MJ, P_MN});
        nvm_wr(16'h8006, 1'b1);
        nvm_wr(16'h8005, 1'b1);
    endtask

    // a fetch rides along to prove the first extra cycle stalls the core
    task automatic t_ind(logic [15:0] p);
        logic [14:0] hold;
        {ind_req, ind_we, indirect_pointer, fetch_req} = {2'b10, p, 1'b1};
        tick();
        ind_req = 1'b0;
        hold = pc;
        chk(pfm_rd, 1'b1);
        chk(ind_pfm_busy, 1'b1);
        chk(pfm_raddr, p[14:0] & 15'(MEM - 1));
        tick();
        fetch_req = 1'b0;
        chk(pc, hold);
        chk(ind_done, 1'b0);
        chk(fetch_valid, 1'b0);
        tick();
        chk(ind_done, 1'b1);
        chk(ind_pfm_busy, 1'b0);
        chk(ind_rdata, p[7:0] ^ 8'h3c);
        tick();
    endtask

    task automatic t_ind_wr();
        {ind_req, ind_we, indirect_pointer} = {2'b11, 16'h8040};
        tick();
        chk(ind_done, 1'b1);
        chk(pfm_rd, 1'b0);
        {ind_we, indirect_pointer} = {1'b0, 16'h0040};
        tick();
        ind_req = 1'b0;
        chk(pfm_rd, 1'b0);
        tick(2);
    endtask

    task automatic t_regions();
        logic [15:0] ra [5] = '{16'h0ff0, 16'hf010, 16'h8007, 16'h0100, 16'h0400};
        for (int i = 0; i < 5; i++) begin
            cfg(1'b1, 1'b0, 3'h7, 1'b0, ~(5'h01 << i));
            for (int j = 0; j < 5; j++) nvm_wr(ra[j], i == j);
        end
        cfg(1'b1, 1'b1, 3'h7, 1'b1, 5'h0f);
        nvm_wr(16'h0000, 1'b1);
        nvm_wr(16'h0fff, 1'b1);
    endtask

    task automatic t_boot_sizes();
        logic [15:0] tbl, last;
        for (int c = 0; c < 8; c++) begin
            tbl = (c == 7) ? 16'h01ff : (c == 6) ? 16'h03ff : (c == 5) ? 16'h07ff : (c == 4) ? 16'h0fff :
                (c == 3) ? 16'h1fff : 16'h3fff;
            last = (tbl > 16'(MEM / 2 - 1)) ? 16'(MEM / 2 - 1) : tbl;
            cfg(1'b1, 1'b0, 3'(c), 1'b1, 5'h17);
            nvm_wr(last, 1'b1);
            nvm_wr(last + 16'h0001, 1'b0);
        end
        cfg(1'b0, 1'b0, 3'h7, 1'b1, 5'h1f);
        nvm_wr(16'h0000, 1'b1);
    endtask

    task automatic t_saf_exec();
        cfg(1'b1, 1'b1, 3'h7, 1'b0, 5'h1f);
        t_ind(16'hff85);
        step(0, 0, 1, 15'h0f7f);
        step(1, 0, 0, 15'h0000);
        chk(pc, 15'h0f80);
        chk(exec_violation_reset, 1'b0);
        step(1, 0, 0, 15'h0000);
        chk(exec_violation_reset, 1'b1);
        chk(pc, 15'h0000);
        chk(exec_violation_flag, 1'b0);
        step(0, 0, 0, 15'h0000);
        reset = 1'b1;
        tick(2);
        reset = 1'b0;
        chk(pc, 15'h0000);
        chk(exec_violation_flag, 1'b1);
    endtask

    initial begin
        tick(4);
        reset = 1'b0;
        t_fetch();
        t_ids();
        t_ind(16'h8123);
        t_ind(16'hc2a7);
        t_ind_wr();
        t_regions();
        t_boot_sizes();
        t_saf_exec();
        complete_run();
    end

    // hang guard: far beyond the longest scenario chain
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        complete_run();
    end
endmodule
